// file: design/mrf_latch_field.sv
// latching status field: holds its tripped value until read or reset
`timescale 1ns/10ps
module mrf_latch_field #(
    parameter int W = 1,
    parameter bit LATCH_HIGH = 1'b1
) (
    input wire logic i_sys_clk,
    input wire logic i_ce,
    input wire logic i_rst,
    input wire logic [W-1:0] i_cond,
    input wire logic i_clr,
    output logic [W-1:0] o_val
);
    logic [W-1:0] trip_q;
    logic [W-1:0] active;

    assign active = LATCH_HIGH ? i_cond : ~i_cond;

    // a condition present in the clearing cycle wins over the clear
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            trip_q <= '0;
        end else if (i_ce) begin
            trip_q <= active | (trip_q & {W{~i_clr}});
        end
    end

    assign o_val = LATCH_HIGH ? trip_q : ~trip_q;
endmodule : mrf_latch_field

// file: design/mrf_mgmt_regs.sv
// management frame engine and register fields of one transceiver port
`timescale 1ns/10ps
module mrf_mgmt_regs #(
    parameter int SWRST_CYCLES = mrf_pkg::SWRST_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire mrf_pkg::mrf_pins_s i_pins,
    output logic o_mdio_out,
    output logic o_mdio_oe_n,
    output mrf_pkg::mrf_ref_src_e o_ref_src,
    output logic o_strap_valid,
    output logic [1:0] o_speed_sel,
    output logic o_loopback,
    output logic o_soft_rst,
    output logic [15:0] o_wo_data,
    output logic o_wo_strobe
);
    // ------------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------------
    mrf_pkg::mrf_pins_s pins_s1_q;
    mrf_pkg::mrf_pins_s pins_s2_q;
    logic mdc_prev_q;
    mrf_pkg::mrf_status_s stat_prev_q;
    logic rise;
    logic fall;

    // no reset: the chain tracks the pins through reset, so no false edge follows it
    always_ff @(posedge i_sys_clk) begin
        if (i_ce) begin
            pins_s1_q <= i_pins;
            pins_s2_q <= pins_s1_q;
            mdc_prev_q <= pins_s2_q.mdc;
            stat_prev_q <= pins_s2_q.status;
        end
    end

    assign rise = pins_s2_q.mdc & ~mdc_prev_q;
    assign fall = ~pins_s2_q.mdc & mdc_prev_q;

    // ------------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------------
    logic [1:0] strap_wait_q;
    logic [4:0] phy_addr_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            strap_wait_q <= '0;
            o_strap_valid <= 1'b0;
            o_ref_src <= mrf_pkg::REF_XTAL_25;
            phy_addr_q <= '0;
        end else if (i_ce && !o_strap_valid) begin
            strap_wait_q <= strap_wait_q + 2'h1;
            if (strap_wait_q == mrf_pkg::STRAP_SETTLE) begin
                o_strap_valid <= 1'b1;
                phy_addr_q <= pins_s2_q.phy_addr;
                unique case (pins_s2_q.clk_sel)
                    mrf_pkg::CLKSEL_XTAL_25: o_ref_src <= mrf_pkg::REF_XTAL_25;
                    mrf_pkg::CLKSEL_DIFF_25: o_ref_src <= mrf_pkg::REF_DIFF_25;
                    mrf_pkg::CLKSEL_CLK_125: o_ref_src <= mrf_pkg::REF_CLK_125;
                    mrf_pkg::CLKSEL_DIFF_156: o_ref_src <= mrf_pkg::REF_DIFF_156;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic swrst_act_q;
    logic [15:0] swrst_cnt_q;
    logic sw_done;
    logic any_rst;
    logic loop_q;
    logic [1:0] spd_pend_q;
    logic [15:0] dflt_q;
    logic [15:0] scr_q;
    logic ros_q;
    logic [7:0] page_q;
    logic ign_hi_q;
    logic ign_lo_q;
    logic [1:0] mmd_fn_q;
    logic [4:0] mmd_devad_q;
    logic [15:0] mmd_addr_q;
    logic link_lat;
    logic fault_lat;
    logic [mrf_pkg::EVT_W-1:0] evt_lat;

    // ------------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------------
    mrf_pkg::mrf_state_e state_q;
    logic [5:0] cnt_q;
    logic [13:0] hdr_q;
    logic [15:0] wdat_q;
    logic [15:0] tx_q;
    logic rd_q;
    logic wr_q;
    logic addr_op_q;
    logic inc_q;
    logic tgt_ok_q;
    logic [7:0] tgt_page_q;
    logic [4:0] tgt_reg_q;
    logic fin;
    logic [1:0] f_st;
    logic [1:0] f_op;
    logic [4:0] f_pa;
    logic [4:0] f_ra;
    logic rd_c;
    logic wr_c;
    logic hit_rd_c;
    logic hit_wr_c;
    logic mmd_c;
    logic tgt_ok_c;
    logic [7:0] c22_page_c;
    logic [7:0] tgt_page_c;
    logic [4:0] tgt_reg_c;
    logic [15:0] rd_word_c;

    assign {f_st, f_op, f_pa, f_ra} = hdr_q;
    assign fin = (state_q == mrf_pkg::S_DATA) && fall && (cnt_q == mrf_pkg::FRAME_BITS);

    always_comb begin
        rd_c = (f_st == mrf_pkg::ST_C22 && f_op == mrf_pkg::OP22_RD)
            || (f_st == mrf_pkg::ST_C45 && (f_op == mrf_pkg::OP45_RD
            || f_op == mrf_pkg::OP45_RDINC));
        wr_c = (f_st == mrf_pkg::ST_C22 && f_op == mrf_pkg::OP22_WR)
            || (f_st == mrf_pkg::ST_C45 && (f_op == mrf_pkg::OP45_WR
            || f_op == mrf_pkg::OP45_ADDR));
        hit_rd_c = f_pa == phy_addr_q;
        hit_wr_c = (ign_hi_q || f_pa[4:2] == phy_addr_q[4:2])
            && (ign_lo_q || f_pa[1:0] == phy_addr_q[1:0]);
        c22_page_c = (f_ra == mrf_pkg::REG_PAGE) ? mrf_pkg::PAGE_ZERO : page_q;
        if (f_st == mrf_pkg::ST_C45) begin
            mmd_c = 1'b1;
        end else begin
            mmd_c = c22_page_c == mrf_pkg::PAGE_ZERO && f_ra == mrf_pkg::REG_MMD_DAT
                && mmd_fn_q != mrf_pkg::MMD_FN_ADDR;
        end
        if (mmd_c) begin
            tgt_reg_c = mmd_addr_q[4:0];
            tgt_page_c = (tgt_reg_c == mrf_pkg::REG_PAGE) ? mrf_pkg::PAGE_ZERO : mmd_addr_q[12:5];
            tgt_ok_c = ((f_st == mrf_pkg::ST_C45) ? f_ra : mmd_devad_q) == mrf_pkg::C22_DEVAD
                && mmd_addr_q[15:13] == mrf_pkg::C22_MAP_TAG;
        end else begin
            tgt_reg_c = f_ra;
            tgt_page_c = c22_page_c;
            tgt_ok_c = 1'b1;
        end
        // unmapped registers and reserved bits read zero
        rd_word_c = '0;
        if (tgt_ok_c && tgt_page_c == mrf_pkg::PAGE_ZERO) begin
            case (tgt_reg_c)
                mrf_pkg::REG_CTRL: begin
                    rd_word_c[mrf_pkg::CTRL_SWRST_BIT] = swrst_act_q;
                    rd_word_c[mrf_pkg::CTRL_LOOP_BIT] = loop_q;
                    rd_word_c[mrf_pkg::CTRL_SPD_HI_BIT] = spd_pend_q[1];
                    rd_word_c[mrf_pkg::CTRL_SPD_LO_BIT] = spd_pend_q[0];
                end
                mrf_pkg::REG_STAT: begin
                    rd_word_c[mrf_pkg::STAT_FAULT_BIT] = fault_lat;
                    rd_word_c[mrf_pkg::STAT_LINK_BIT] = link_lat;
                end
                mrf_pkg::REG_MMD_CTL: begin
                    rd_word_c[mrf_pkg::MMD_FN_MSB:mrf_pkg::MMD_FN_LSB] = mmd_fn_q;
                    rd_word_c[4:0] = mmd_devad_q;
                end
                mrf_pkg::REG_MMD_DAT: rd_word_c = mmd_addr_q;
                mrf_pkg::REG_DFLT: rd_word_c = dflt_q;
                mrf_pkg::REG_EVT: begin
                    rd_word_c[mrf_pkg::EVT_ROS_BIT] = ros_q;
                    rd_word_c[mrf_pkg::EVT_W-1:0] = evt_lat;
                end
                mrf_pkg::REG_SCR: rd_word_c = scr_q;
                mrf_pkg::REG_PAGE: begin
                    rd_word_c[mrf_pkg::PAGE_IGN_HI_BIT] = ign_hi_q;
                    rd_word_c[mrf_pkg::PAGE_IGN_LO_BIT] = ign_lo_q;
                    rd_word_c[7:0] = page_q;
                end
                default: rd_word_c = '0;
            endcase
        end
    end

    // preamble is optional: a zero on an idle line opens a frame
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_q <= mrf_pkg::S_IDLE;
            cnt_q <= '0;
            hdr_q <= '0;
            wdat_q <= '0;
            tx_q <= '0;
            {rd_q, wr_q, addr_op_q, inc_q, tgt_ok_q} <= '0;
            tgt_page_q <= '0;
            tgt_reg_q <= '0;
        end else if (i_ce) begin
            unique case (state_q)
                mrf_pkg::S_IDLE: begin
                    if (rise && !pins_s2_q.mdio) begin
                        state_q <= mrf_pkg::S_HDR;
                        cnt_q <= 6'h01;
                        hdr_q <= '0;
                    end
                end
                mrf_pkg::S_HDR: begin
                    if (cnt_q == mrf_pkg::HDR_BITS) begin
                        state_q <= mrf_pkg::S_DATA;
                        rd_q <= rd_c && hit_rd_c;
                        wr_q <= wr_c && hit_wr_c;
                        addr_op_q <= (f_st == mrf_pkg::ST_C45 && f_op == mrf_pkg::OP45_ADDR)
                            || (f_st == mrf_pkg::ST_C22 && f_ra == mrf_pkg::REG_MMD_DAT
                            && c22_page_c == mrf_pkg::PAGE_ZERO
                            && mmd_fn_q == mrf_pkg::MMD_FN_ADDR);
                        inc_q <= (f_st == mrf_pkg::ST_C45) ? f_op == mrf_pkg::OP45_RDINC
                            : mmd_c && (mmd_fn_q == mrf_pkg::MMD_FN_INC_RW
                            || (mmd_fn_q == mrf_pkg::MMD_FN_INC_WR && wr_c));
                        tgt_ok_q <= tgt_ok_c;
                        tgt_page_q <= tgt_page_c;
                        tgt_reg_q <= tgt_reg_c;
                        tx_q <= rd_word_c;
                    end else if (rise) begin
                        cnt_q <= cnt_q + 6'h01;
                        hdr_q <= {hdr_q[12:0], pins_s2_q.mdio};
                    end
                end
                mrf_pkg::S_DATA: begin
                    if (rise) begin
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q >= mrf_pkg::DATA_FIRST_CNT) begin
                            wdat_q <= {wdat_q[14:0], pins_s2_q.mdio};
                        end
                    end
                    if (fall && rd_q && cnt_q >= mrf_pkg::DATA_FIRST_CNT) begin
                        tx_q <= {tx_q[14:0], 1'b0};
                    end
                    if (fin) begin
                        state_q <= mrf_pkg::S_IDLE;
                    end
                end
                default: state_q <= mrf_pkg::S_IDLE;
            endcase
        end
    end

    // turnaround zero, then data msb first, all changing on mdc fall
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_mdio_out <= 1'b1;
            o_mdio_oe_n <= 1'b1;
        end else if (i_ce && fall && state_q == mrf_pkg::S_DATA && rd_q) begin
            if (cnt_q == mrf_pkg::TA_DRIVE_CNT) begin
                o_mdio_oe_n <= 1'b0;
                o_mdio_out <= 1'b0;
            end else if (cnt_q == mrf_pkg::FRAME_BITS) begin
                o_mdio_oe_n <= 1'b1;
                o_mdio_out <= 1'b1;
            end else if (cnt_q >= mrf_pkg::DATA_FIRST_CNT) begin
                o_mdio_out <= tx_q[15];
            end
        end
    end

    // ------------------------------------------------------------------
    // register writes, side effects and soft reset
    // ------------------------------------------------------------------
    logic wr_fin;
    logic wr_p0;
    logic rd_p0;

    assign wr_fin = fin && wr_q;
    assign wr_p0 = wr_fin && !addr_op_q && tgt_ok_q && tgt_page_q == mrf_pkg::PAGE_ZERO;
    assign rd_p0 = fin && rd_q && tgt_ok_q && tgt_page_q == mrf_pkg::PAGE_ZERO;
    assign sw_done = swrst_act_q && swrst_cnt_q == 16'(SWRST_CYCLES - 1);
    assign any_rst = i_srst || (i_ce && sw_done);

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            swrst_act_q <= 1'b0;
            swrst_cnt_q <= '0;
            o_soft_rst <= 1'b0;
        end else if (i_ce) begin
            o_soft_rst <= sw_done;
            if (sw_done) begin
                swrst_act_q <= 1'b0;
            end else if (swrst_act_q) begin
                swrst_cnt_q <= swrst_cnt_q + 16'h0001;
            end else if (wr_p0 && tgt_reg_q == mrf_pkg::REG_CTRL
                && wdat_q[mrf_pkg::CTRL_SWRST_BIT]) begin
                swrst_act_q <= 1'b1;
                swrst_cnt_q <= '0;
            end
        end
    end

    // fields returned to their reset values by either reset
    always_ff @(posedge i_sys_clk) begin
        if (any_rst) begin
            loop_q <= 1'b0;
            scr_q <= '0;
            dflt_q <= mrf_pkg::DFLT_RST;
        end else if (i_ce && wr_p0) begin
            if (tgt_reg_q == mrf_pkg::REG_CTRL) begin
                loop_q <= wdat_q[mrf_pkg::CTRL_LOOP_BIT];
            end
            if (tgt_reg_q == mrf_pkg::REG_SCR) begin
                scr_q <= wdat_q;
            end
            if (tgt_reg_q == mrf_pkg::REG_DFLT) begin
                dflt_q <= wdat_q;
            end
        end
    end

    // page and indirect access state only clear on hardware reset
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            page_q <= '0;
            ign_hi_q <= 1'b0;
            ign_lo_q <= 1'b0;
            mmd_fn_q <= '0;
            mmd_devad_q <= '0;
            mmd_addr_q <= '0;
        end else if (i_ce) begin
            if (wr_p0 && tgt_reg_q == mrf_pkg::REG_PAGE) begin
                page_q <= wdat_q[7:0];
                ign_hi_q <= wdat_q[mrf_pkg::PAGE_IGN_HI_BIT];
                ign_lo_q <= wdat_q[mrf_pkg::PAGE_IGN_LO_BIT];
            end
            if (wr_p0 && tgt_reg_q == mrf_pkg::REG_MMD_CTL) begin
                mmd_fn_q <= wdat_q[mrf_pkg::MMD_FN_MSB:mrf_pkg::MMD_FN_LSB];
                mmd_devad_q <= wdat_q[4:0];
            end
            if ((wr_fin && addr_op_q) || (wr_p0 && tgt_reg_q == mrf_pkg::REG_MMD_DAT)) begin
                mmd_addr_q <= wdat_q;
            end else if (fin && inc_q && (rd_q || wr_q)) begin
                mmd_addr_q <= mmd_addr_q + 16'h0001;
            end
        end
    end

    // speed bits wait for the next soft reset before steering anything
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            spd_pend_q <= mrf_pkg::SPD_RST;
            o_speed_sel <= mrf_pkg::SPD_RST;
        end else if (i_ce) begin
            if (sw_done) begin
                o_speed_sel <= spd_pend_q;
            end
            if (wr_p0 && tgt_reg_q == mrf_pkg::REG_CTRL) begin
                spd_pend_q <= {wdat_q[mrf_pkg::CTRL_SPD_HI_BIT],
                    wdat_q[mrf_pkg::CTRL_SPD_LO_BIT]};
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (any_rst) begin
            ros_q <= 1'b0;
        end else if (i_ce && rd_p0 && tgt_reg_q == mrf_pkg::REG_EVT) begin
            ros_q <= 1'b1;
        end
    end

    // write-only word is not kept readable
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_wo_data <= '0;
            o_wo_strobe <= 1'b0;
        end else if (i_ce) begin
            o_wo_strobe <= wr_p0 && tgt_reg_q == mrf_pkg::REG_WO;
            if (wr_p0 && tgt_reg_q == mrf_pkg::REG_WO) begin
                o_wo_data <= wdat_q;
            end
        end
    end

    assign o_loopback = loop_q;

    // ------------------------------------------------------------------
    // latching and read-clear status fields
    // ------------------------------------------------------------------
    mrf_latch_field #(.W(1), .LATCH_HIGH(1'b0)) u_link (
        .i_sys_clk(i_sys_clk),
        .i_ce(i_ce),
        .i_rst(any_rst),
        .i_cond(pins_s2_q.status.link_ok),
        .i_clr(rd_p0 && tgt_reg_q == mrf_pkg::REG_STAT),
        .o_val(link_lat)
    );

    mrf_latch_field #(.W(1), .LATCH_HIGH(1'b1)) u_fault (
        .i_sys_clk(i_sys_clk),
        .i_ce(i_ce),
        .i_rst(any_rst),
        .i_cond(pins_s2_q.status.remote_fault),
        .i_clr(rd_p0 && tgt_reg_q == mrf_pkg::REG_STAT),
        .o_val(fault_lat)
    );

    mrf_latch_field #(.W(mrf_pkg::EVT_W), .LATCH_HIGH(1'b1)) u_evt (
        .i_sys_clk(i_sys_clk),
        .i_ce(i_ce),
        .i_rst(any_rst),
        .i_cond(pins_s2_q.status & ~stat_prev_q),
        .i_clr(rd_p0 && tgt_reg_q == mrf_pkg::REG_EVT),
        .o_val(evt_lat)
    );
endmodule : mrf_mgmt_regs

// file: design/mrf_pkg.sv
// constants, types and carriers shared by the management register block
//
// Functional notes
// - decode two-bit reference clock strap into source
// - accept clause 22 and clause 45 frames
// - clause 22 reaches clause 45 via regs 13/14
// - read-clear fields return value, then clear
// - latch-high field holds one until read/reset
// - latch-low field holds zero until read/reset
// - retain fields survive soft reset, not hardware
// - reserved bits always read as zero
// - set-on-read field goes high after read
// - rw reset-clear fields writable, reset to zero
// - rw reset-set fields writable, nonzero reset default
// - self-clear bit starts function, clears when done
// - deferred fields take effect at soft reset
// - write-only fields accept writes, reads undefined
// - reg 22 low byte pages other registers
package mrf_pkg;

    // ------------------------------------------------------------------
    // frame codes
    // ------------------------------------------------------------------
    localparam logic [1:0] ST_C22 = 2'h1;
    localparam logic [1:0] ST_C45 = 2'h0;
    localparam logic [1:0] OP22_RD = 2'h2;
    localparam logic [1:0] OP22_WR = 2'h1;
    localparam logic [1:0] OP45_ADDR = 2'h0;
    localparam logic [1:0] OP45_WR = 2'h1;
    localparam logic [1:0] OP45_RD = 2'h3;
    localparam logic [1:0] OP45_RDINC = 2'h2;
    localparam logic [5:0] HDR_BITS = 6'h0e;
    localparam logic [5:0] TA_DRIVE_CNT = 6'h0f;
    localparam logic [5:0] DATA_FIRST_CNT = 6'h10;
    localparam logic [5:0] FRAME_BITS = 6'h20;

    // ------------------------------------------------------------------
    // register addresses and field positions
    // ------------------------------------------------------------------
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STAT = 5'h01;
    localparam logic [4:0] REG_MMD_CTL = 5'h0d;
    localparam logic [4:0] REG_MMD_DAT = 5'h0e;
    localparam logic [4:0] REG_DFLT = 5'h10;
    localparam logic [4:0] REG_EVT = 5'h11;
    localparam logic [4:0] REG_SCR = 5'h12;
    localparam logic [4:0] REG_WO = 5'h13;
    localparam logic [4:0] REG_PAGE = 5'h16;
    localparam int CTRL_SWRST_BIT = 15;
    localparam int CTRL_LOOP_BIT = 14;
    localparam int CTRL_SPD_HI_BIT = 13;
    localparam int CTRL_SPD_LO_BIT = 6;
    localparam int STAT_FAULT_BIT = 4;
    localparam int STAT_LINK_BIT = 2;
    localparam int EVT_ROS_BIT = 15;
    localparam int EVT_W = 3;
    localparam int PAGE_IGN_HI_BIT = 15;
    localparam int PAGE_IGN_LO_BIT = 14;
    localparam int MMD_FN_MSB = 15;
    localparam int MMD_FN_LSB = 14;
    localparam logic [1:0] MMD_FN_ADDR = 2'h0;
    localparam logic [1:0] MMD_FN_INC_RW = 2'h2;
    localparam logic [1:0] MMD_FN_INC_WR = 2'h3;
    localparam logic [4:0] C22_DEVAD = 5'h03;
    localparam logic [2:0] C22_MAP_TAG = 3'h4;
    localparam logic [7:0] PAGE_ZERO = 8'h00;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] DFLT_RST = 16'h0001;
    localparam logic [1:0] SPD_RST = 2'h2;

    // ------------------------------------------------------------------
    // strap codes and timing
    // ------------------------------------------------------------------
    localparam logic [1:0] CLKSEL_XTAL_25 = 2'h3;
    localparam logic [1:0] CLKSEL_DIFF_25 = 2'h2;
    localparam logic [1:0] CLKSEL_CLK_125 = 2'h1;
    localparam logic [1:0] CLKSEL_DIFF_156 = 2'h0;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SWRST_TIME_NS = 1000;
    localparam int SWRST_CYC = (SWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        REF_XTAL_25 = 4'h1,
        REF_DIFF_25 = 4'h2,
        REF_CLK_125 = 4'h4,
        REF_DIFF_156 = 4'h8
    } mrf_ref_src_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_HDR = 3'h2,
        S_DATA = 3'h4
    } mrf_state_e;

    typedef struct packed {
        logic link_ok;
        logic remote_fault;
        logic energy_det;
    } mrf_status_s;

    typedef struct packed {
        logic mdc;
        logic mdio;
        logic [1:0] clk_sel;
        logic [4:0] phy_addr;
        mrf_status_s status;
    } mrf_pins_s;

endpackage : mrf_pkg

// file: sim/mrf_mgmt_regs_bench.sv
// self-checking bench for the management register block
`timescale 1ns/10ps
module mrf_mgmt_regs_bench;
    localparam logic [4:0] PA = 5'h05;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [1:0] sel = 2'h3;
    mrf_pkg::mrf_status_s st = 3'h4;
    logic mdc, mdio, mout, moe_n, sv, srp, wst, lb;
    logic [1:0] spd;
    logic [15:0] wod, q;
    mrf_pkg::mrf_ref_src_e ref_src;
    mrf_pkg::mrf_pins_s pins;
    int miscompares = 0;
    int checks = 0;
    assign pins = {mdc, mdio, sel, PA, st};
    initial forever #12.5 clk = ~clk;
    mrf_mgmt_regs #(.SWRST_CYCLES(4)) i_mrf_mgmt_regs (.i_sys_clk(clk), .i_srst(srst),
        .i_ce(1'b1), .i_pins(pins), .o_mdio_out(mout), .o_mdio_oe_n(moe_n), .o_ref_src(ref_src),
        .o_strap_valid(sv), .o_speed_sel(spd), .o_loopback(lb), .o_soft_rst(srp),
        .o_wo_data(wod), .o_wo_strobe(wst));
    mrf_mgr i_mrf_mgr (.i_dev_out(mout), .i_dev_oe_n(moe_n), .o_mdc(mdc), .o_mdio(mdio));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic rc(input logic [4:0] r, input logic [15:0] e);
        i_mrf_mgr.frame(mrf_pkg::ST_C22, mrf_pkg::OP22_RD, PA, r, 16'h0, q);
        chk(q, e);
    endtask : rc
    task automatic wr(input logic [4:0] r, input logic [15:0] d);
        i_mrf_mgr.frame(mrf_pkg::ST_C22, mrf_pkg::OP22_WR, PA, r, d, q);
    endtask : wr
    task automatic t_strap();
        for (int k = 0; k < 4; k++) begin
            cyc(1);
            srst = 1'b1;
            sel = k[1:0];
            cyc(6);
            srst = 1'b0;
            cyc(12);
            chk({12'h0, ref_src}, {12'h0, 4'h8 >> k});
        end
        $display("strap test done");
    endtask : t_strap
    task automatic t_regs();
        rc(5'h10, 16'h0001);
        rc(5'h12, 16'h0000);
        wr(5'h12, 16'ha5c3);
        rc(5'h12, 16'ha5c3);
        i_mrf_mgr.frame(mrf_pkg::ST_C45, mrf_pkg::OP45_ADDR, PA, 5'h03, 16'h8012, q);
        i_mrf_mgr.frame(mrf_pkg::ST_C45, mrf_pkg::OP45_RD, PA, 5'h03, 16'h0, q);
        chk(q, 16'ha5c3);
        wr(5'h0d, 16'h4003);
        rc(5'h0e, 16'ha5c3);
        rc(5'h16, 16'h0000);
        wr(5'h13, 16'h3c5a);
        chk(wod, 16'h3c5a);
        $display("register test done");
    endtask : t_regs
    task automatic t_latch();
        i_mrf_mgr.frame(mrf_pkg::ST_C22, mrf_pkg::OP22_RD, PA, 5'h01, 16'h0, q);
        cyc(2);
        st.remote_fault = 1'b1;
        cyc(8);
        st = 3'h0;
        cyc(8);
        st.link_ok = 1'b1;
        cyc(8);
        rc(5'h01, 16'h0010);
        rc(5'h01, 16'h0004);
        $display("latch test done");
    endtask : t_latch
    task automatic t_events();
        i_mrf_mgr.frame(mrf_pkg::ST_C22, mrf_pkg::OP22_RD, PA, 5'h11, 16'h0, q);
        cyc(2);
        st.energy_det = 1'b1;
        cyc(8);
        rc(5'h11, 16'h8001);
        rc(5'h11, 16'h8000);
        $display("event test done");
    endtask : t_events
    task automatic t_soft();
        wr(5'h16, 16'h4001);
        rc(5'h10, 16'h0000);
        rc(5'h16, 16'h4001);
        wr(5'h16, 16'h4000);
        wr(5'h10, 16'h00ff);
        wr(5'h00, 16'h4000);
        chk({14'h0, spd}, 16'h0002);
        chk({15'h0, lb}, 16'h0001);
        wr(5'h00, 16'hc000);
        cyc(10);
        chk({14'h0, spd}, 16'h0000);
        chk({15'h0, lb}, 16'h0000);
        rc(5'h00, 16'h0000);
        rc(5'h16, 16'h4000);
        rc(5'h10, 16'h0001);
        $display("soft reset test done");
    endtask : t_soft
    task automatic summarize();
        $display("checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    initial begin
        t_strap();
        t_regs();
        t_latch();
        t_events();
        t_soft();
        summarize();
    end
    // about 25 frames of 6.6 us each are expected; allow several times that
    initial begin
        #1000000;
        miscompares++;
        summarize();
    end
endmodule : mrf_mgmt_regs_bench

// file: sim/mrf_mgmt_regs_chk.sv
// port checker for the management register block
`timescale 1ns/10ps
module mrf_mgmt_regs_chk (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire mrf_pkg::mrf_pins_s i_pins,
    input wire logic o_mdio_out,
    input wire logic o_mdio_oe_n,
    input wire mrf_pkg::mrf_ref_src_e o_ref_src,
    input wire logic o_strap_valid,
    input wire logic [1:0] o_speed_sel,
    input wire logic o_loopback,
    input wire logic o_soft_rst,
    input wire logic [15:0] o_wo_data,
    input wire logic o_wo_strobe
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);
    AST_REF_DECODE: assert property (o_strap_valid |-> o_ref_src == (4'h1 << ~i_pins.clk_sel))
        else $error("strap decode wrong");
    AST_STRAP_TIME: assert property ($fell(i_srst) |-> ##[1:6] o_strap_valid)
        else $error("strap not captured");
    AST_TA_ZERO: assert property ($fell(o_mdio_oe_n) |-> !o_mdio_out)
        else $error("turnaround not zero");
    AST_DRIVE_SPAN: assert property ($fell(o_mdio_oe_n) |-> !o_mdio_oe_n [*8])
        else $error("read drive too short");
    AST_SOFT_PULSE: assert property (o_soft_rst |=> !o_soft_rst)
        else $error("soft reset pulse too long");
    AST_SOFT_LOOP: assert property (o_soft_rst |-> !o_loopback)
        else $error("loopback survived soft reset");
    AST_SPEED_DEFER: assert property ($changed(o_speed_sel) && !$past(i_srst) |-> ##[0:2] o_soft_rst)
        else $error("speed applied without soft reset");
    AST_WO_STROBE: assert property ($changed(o_wo_data) && !$past(i_srst) |-> ##[0:1] o_wo_strobe)
        else $error("write-only data without strobe");
endmodule : mrf_mgmt_regs_chk
bind mrf_mgmt_regs mrf_mgmt_regs_chk i_mrf_mgmt_regs_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_ce(i_ce), .i_pins(i_pins), .o_mdio_out(o_mdio_out), .o_mdio_oe_n(o_mdio_oe_n),
    .o_ref_src(o_ref_src), .o_strap_valid(o_strap_valid), .o_speed_sel(o_speed_sel),
    .o_loopback(o_loopback), .o_soft_rst(o_soft_rst), .o_wo_data(o_wo_data),
    .o_wo_strobe(o_wo_strobe));

// file: sim/mrf_mgr.sv
// station manager model: mdc runs only within frames, mdio has a pull-up
`timescale 1ns/10ps
module mrf_mgr (
    input wire logic i_dev_out,
    input wire logic i_dev_oe_n,
    output logic o_mdc,
    output logic o_mdio
);
    logic drv = 1'b0;
    logic bit_q = 1'b1;
    assign o_mdio = !i_dev_oe_n ? i_dev_out : (drv ? bit_q : 1'b1);
    initial o_mdc = 1'b0;
    // read data is sampled late in the high phase, clear of the device's sync lag
    task automatic frame(input logic [1:0] st, input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] f;
        f = {st, op, pa, ra, 2'h2, wd};
        for (int i = 0; i < 33; i++) begin
            drv = (i < 14) || (i < 32 && !op[1]);
            bit_q = (i < 32) ? f[31-i] : 1'b1;
            #100 o_mdc = 1'b1;
            #99;
            if (i >= 16 && i < 32) rd[31-i] = o_mdio;
            #1 o_mdc = 1'b0;
        end
        drv = 1'b0;
    endtask : frame
endmodule : mrf_mgr
